// ---- hdl/lvds_serdes_pkg.sv ----
// constants, register map and types for the source-synchronous lvds channel
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package lvds_serdes_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] STATUS_OFS  = 8'h04;
  localparam logic [7:0] RXDATA_OFS  = 8'h08;

  // control fields
  localparam int J_LSB      = 0;
  localparam int W_LSB      = 4;
  localparam int PAEN_BIT   = 12;
  localparam int TXEN_BIT   = 13;
  localparam logic [3:0] J_RST    = 4'h8;
  localparam logic [5:0] W_RST    = 6'h02;
  localparam logic       PAEN_RST = 1'b1;
  localparam logic       TXEN_RST = 1'b1;
  localparam logic [3:0] J_MIN    = 4'h4;
  localparam logic [3:0] J_MAX    = 4'hA;
  localparam logic [5:0] W_MAX    = 6'h20;

  // status fields
  localparam int LOCK_BIT   = 0;
  localparam int PHASE_LSB  = 1;
  localparam int DROP_BIT   = 4;
  localparam int SLIP_LSB   = 8;

  // link figures
  localparam int WORD_MAX      = 10;
  localparam int PA_TAPS       = 8;
  localparam int MAX_RATE_MBPS = 1000;
  localparam int WIN_LEN_RST   = 64;

  typedef enum logic [1:0] {PA_BYPASS, PA_TRAIN, PA_LOCKED} pa_state_t;

endpackage

// ---- hdl/lvds_serdes_dpa_channel.sv ----
// one receive and one transmit lane with phase aligner, realigner and apb control
//
// Chosen here: the APB register port and the address map.
module lvds_serdes_dpa_channel
  import lvds_serdes_pkg::*;
#(
  parameter int ADDR_W  = 8,
  parameter int WIN_LEN = WIN_LEN_RST
)
(
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic                ce,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                lnk_clk,
  input  wire logic                rx_serial,
  input  wire logic [PA_TAPS-1:0]  rx_phase_taps,
  output logic                     tx_serial,
  output logic                     tx_fwd_clk,
  output logic      [WORD_MAX-1:0] rx_word,
  output logic                     rx_word_vld,
  input  wire logic                realign_req,
  input  wire logic [WORD_MAX-1:0] tx_word,
  input  wire logic                tx_word_vld,
  output logic                     tx_word_rdy
);

  if (ADDR_W < 8 || WIN_LEN < 2 || WIN_LEN > 256)
  begin : g_param_check
    $error("lvds_serdes_dpa_channel: ADDR_W >= 8 and WIN_LEN in 2..256 required");
  end

  function automatic logic j_ok(input logic [3:0] j);
    j_ok = (j == 4'h1) || (j == 4'h2) || ((j >= J_MIN) && (j <= J_MAX));
  endfunction

  function automatic logic w_ok(input logic [5:0] w);
    w_ok = (w != 6'h00) && (w <= W_MAX);
  endfunction

  //----------------------------------------------------------------------------
  // system clock domain: apb slave and control
  //----------------------------------------------------------------------------
  logic [3:0]          j_ff;
  logic [5:0]          w_ff;
  logic                pa_en_ff;
  logic                tx_en_ff;
  logic                cfg_tgl_ff;
  logic                pready_ff;
  logic                pslverr_ff;
  logic [31:0]         prdata_ff;
  logic [31:0]         nxt_prdata;
  logic                nxt_pslverr;
  logic                drop_ff;
  logic [7:0]          slip_cnt_ff;
  logic                slip_tgl_ff;
  logic                lock_ff;
  logic [2:0]          phase_ff;
  logic [WORD_MAX-1:0] rx_word_ff;
  logic                rx_word_vld_ff;
  logic                rx_ack_tgl_ff;
  logic [2:0]          rx_tgl_sync_ff;
  logic [2:0]          drop_sync_ff;
  logic [1:0]          tx_ack_sync_ff;
  logic [WORD_MAX-1:0] tx_hold_ff;
  logic                tx_tgl_ff;
  logic                tx_word_rdy_ff;
  logic                setup;
  logic                wr_take;
  logic                wr_ctrl_ok;
  logic                wr_status;
  logic                rx_evt;
  logic                drop_evt;

  // link-side registers read by this domain only after a toggle has settled
  logic [WORD_MAX-1:0] rx_x_word_ff;
  logic [2:0]          rx_x_phase_ff;
  logic                rx_x_lock_ff;
  logic                rx_tgl_ff;
  logic                drop_tgl_ff;
  logic                tx_ack_tgl_ff;

  assign setup      = psel & ~penable;
  assign wr_take    = psel & penable & pready_ff & pwrite & ~pslverr_ff;
  assign wr_ctrl_ok = wr_take && (paddr[7:0] == CTRL_OFS);
  assign wr_status  = wr_take && (paddr[7:0] == STATUS_OFS);
  assign rx_evt     = rx_tgl_sync_ff[1] ^ rx_tgl_sync_ff[2];
  assign drop_evt   = drop_sync_ff[1] ^ drop_sync_ff[2];

  // decode in the setup cycle so the access phase completes with no wait state
  always_comb
  begin
    nxt_prdata  = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    case (paddr[7:0])
      CTRL_OFS:
      begin
        nxt_prdata[J_LSB +: 4] = j_ff;
        nxt_prdata[W_LSB +: 6] = w_ff;
        nxt_prdata[PAEN_BIT]   = pa_en_ff;
        nxt_prdata[TXEN_BIT]   = tx_en_ff;
        if (pwrite && !(j_ok(pwdata[J_LSB +: 4]) && w_ok(pwdata[W_LSB +: 6])))
        begin
          nxt_pslverr = 1'b1;
        end
      end
      STATUS_OFS:
      begin
        nxt_prdata[LOCK_BIT]       = lock_ff;
        nxt_prdata[PHASE_LSB +: 3] = phase_ff;
        nxt_prdata[DROP_BIT]       = drop_ff;
        nxt_prdata[SLIP_LSB +: 8]  = slip_cnt_ff;
      end
      RXDATA_OFS:
      begin
        nxt_prdata[WORD_MAX-1:0] = rx_word_ff;
      end
      default:
      begin
        nxt_pslverr = 1'b1;
      end
    endcase
    // shift rather than slice: a slice above bit 7 is empty at the default width
    if ((paddr >> 8) != '0)
    begin
      nxt_pslverr = 1'b1;
      nxt_prdata  = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end
    else if (ce)
    begin
      pready_ff  <= setup;
      pslverr_ff <= setup & nxt_pslverr;
      prdata_ff  <= setup ? nxt_prdata : 32'h0000_0000;
    end
  end

  // factors are written together and must both be legal, else the write is refused
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      j_ff       <= J_RST;
      w_ff       <= W_RST;
      pa_en_ff   <= PAEN_RST;
      tx_en_ff   <= TXEN_RST;
      cfg_tgl_ff <= 1'b0;
    end
    else if (ce && wr_ctrl_ok)
    begin
      j_ff       <= pwdata[J_LSB +: 4];
      w_ff       <= pwdata[W_LSB +: 6];
      pa_en_ff   <= pwdata[PAEN_BIT];
      tx_en_ff   <= pwdata[TXEN_BIT];
      cfg_tgl_ff <= ~cfg_tgl_ff;
    end
  end

  // realign requests come from fabric logic on this clock; factors 1 and 2 have
  // no word boundary so requests are ignored there
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      slip_tgl_ff <= 1'b0;
      slip_cnt_ff <= 8'h00;
    end
    else if (ce && realign_req && (j_ff > 4'h2))
    begin
      slip_tgl_ff <= ~slip_tgl_ff;
      slip_cnt_ff <= slip_cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rx_tgl_sync_ff <= 3'h0;
      drop_sync_ff   <= 3'h0;
      tx_ack_sync_ff <= 2'h0;
    end
    else if (ce)
    begin
      rx_tgl_sync_ff <= {rx_tgl_sync_ff[1:0], rx_tgl_ff};
      drop_sync_ff   <= {drop_sync_ff[1:0], drop_tgl_ff};
      tx_ack_sync_ff <= {tx_ack_sync_ff[0], tx_ack_tgl_ff};
    end
  end

  // received word handshake; the ack lets the link launch its next word
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rx_word_ff     <= '0;
      rx_word_vld_ff <= 1'b0;
      rx_ack_tgl_ff  <= 1'b0;
      lock_ff        <= 1'b0;
      phase_ff       <= 3'h0;
    end
    else if (ce)
    begin
      rx_word_vld_ff <= rx_evt;
      if (rx_evt)
      begin
        rx_word_ff    <= rx_x_word_ff;
        lock_ff       <= rx_x_lock_ff;
        phase_ff      <= rx_x_phase_ff;
        rx_ack_tgl_ff <= ~rx_ack_tgl_ff;
      end
    end
  end

  // sticky: a new drop in the clearing cycle wins
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      drop_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (drop_evt)
      begin
        drop_ff <= 1'b1;
      end
      else if (wr_status && pwdata[DROP_BIT])
      begin
        drop_ff <= 1'b0;
      end
    end
  end

  // transmit word handshake: ready returns once the link has taken the word
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      tx_hold_ff     <= '0;
      tx_tgl_ff      <= 1'b0;
      tx_word_rdy_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (tx_word_vld && tx_word_rdy_ff)
      begin
        tx_hold_ff     <= tx_word;
        tx_tgl_ff      <= ~tx_tgl_ff;
        tx_word_rdy_ff <= 1'b0;
      end
      else
      begin
        tx_word_rdy_ff <= tx_en_ff && (tx_ack_sync_ff[1] == tx_tgl_ff);
      end
    end
  end

  assign prdata      = prdata_ff;
  assign pready      = pready_ff;
  assign pslverr     = pslverr_ff;
  assign rx_word     = rx_word_ff;
  assign rx_word_vld = rx_word_vld_ff;
  assign tx_word_rdy = tx_word_rdy_ff;

  //----------------------------------------------------------------------------
  // link clock domain: fast serial clock from the clock unit
  //----------------------------------------------------------------------------
  logic [1:0]          lrst_sync_ff;
  logic [1:0]          lce_sync_ff;
  logic                lrst_b;
  logic                lce;
  logic [2:0]          cfg_sync_ff;
  logic [2:0]          slip_sync_ff;
  logic [2:0]          tx_sync_ff;
  logic [1:0]          rx_ack_sync_ff;
  logic [1:0]          rx_pin_sync_ff;
  logic [PA_TAPS-1:0]  tap_s1_ff;
  logic [PA_TAPS-1:0]  tap_s2_ff;
  logic                tap_last_ff;
  logic [3:0]          l_j_ff;
  logic [5:0]          l_w_ff;
  logic                l_pa_ff;
  logic [7:0]          edge_cnt_ff [PA_TAPS];
  logic [7:0]          win_cnt_ff;
  pa_state_t           pa_state_ff;
  logic [2:0]          sel_ff;
  logic                sync_bit_ff;
  logic [WORD_MAX-1:0] sr_ff;
  logic [3:0]          bit_cnt_ff;
  logic [WORD_MAX-1:0] pend_ff;
  logic                pend_vld_ff;
  logic [WORD_MAX-1:0] tx_sh_ff;
  logic [3:0]          tx_cnt_ff;
  logic                tx_serial_ff;
  logic [5:0]          fwd_cnt_ff;
  logic                tx_fwd_clk_ff;
  logic                cfg_evt;
  logic                slip_evt;
  logic                tx_evt;
  logic                win_end;
  logic                rx_busy;
  logic [2:0]          best;
  logic [7:0]          best_cnt;
  logic [WORD_MAX-1:0] sr_nxt;
  logic [WORD_MAX-1:0] word_mask;
  logic [WORD_MAX-1:0] tx_cur;
  logic [3:0]          l_j_m1;
  logic [5:0]          w_half;

  assign lrst_b    = lrst_sync_ff[1];
  assign lce       = lce_sync_ff[1];
  assign cfg_evt   = cfg_sync_ff[1] ^ cfg_sync_ff[2];
  assign slip_evt  = slip_sync_ff[1] ^ slip_sync_ff[2];
  assign tx_evt    = tx_sync_ff[1] ^ tx_sync_ff[2];
  assign rx_busy   = rx_tgl_ff != rx_ack_sync_ff[1];
  assign win_end   = win_cnt_ff == 8'(WIN_LEN - 1);
  assign l_j_m1    = l_j_ff - 4'h1;
  assign w_half    = (l_w_ff + 6'h01) >> 1;
  assign sr_nxt    = {sr_ff[WORD_MAX-2:0], sync_bit_ff};
  assign word_mask = ~({WORD_MAX{1'b1}} << l_j_ff);
  assign tx_cur    = (tx_cnt_ff == 4'h0) ? (pend_vld_ff ? pend_ff : '0) : tx_sh_ff;

  // reset and freeze reach this domain only through two flip-flops
  always_ff @(posedge lnk_clk)
  begin
    lrst_sync_ff <= {lrst_sync_ff[0], rst_b};
    lce_sync_ff  <= {lce_sync_ff[0], ce};
  end

  // pins are retimed twice before the phase aligner looks at them
  always_ff @(posedge lnk_clk)
  begin
    if (!lrst_b)
    begin
      rx_pin_sync_ff <= 2'h0;
      tap_s1_ff      <= '0;
      tap_s2_ff      <= '0;
      tap_last_ff    <= 1'b0;
      cfg_sync_ff    <= 3'h0;
      slip_sync_ff   <= 3'h0;
      tx_sync_ff     <= 3'h0;
      rx_ack_sync_ff <= 2'h0;
    end
    else if (lce)
    begin
      rx_pin_sync_ff <= {rx_pin_sync_ff[0], rx_serial};
      tap_s1_ff      <= rx_phase_taps;
      tap_s2_ff      <= tap_s1_ff;
      tap_last_ff    <= tap_s2_ff[PA_TAPS-1];
      cfg_sync_ff    <= {cfg_sync_ff[1:0], cfg_tgl_ff};
      slip_sync_ff   <= {slip_sync_ff[1:0], slip_tgl_ff};
      tx_sync_ff     <= {tx_sync_ff[1:0], tx_tgl_ff};
      rx_ack_sync_ff <= {rx_ack_sync_ff[0], rx_ack_tgl_ff};
    end
  end

  // control bus is held steady while its toggle crosses
  always_ff @(posedge lnk_clk)
  begin
    if (!lrst_b)
    begin
      l_j_ff  <= J_RST;
      l_w_ff  <= W_RST;
      l_pa_ff <= PAEN_RST;
    end
    else if (lce && cfg_evt)
    begin
      l_j_ff  <= j_ff;
      l_w_ff  <= w_ff;
      l_pa_ff <= pa_en_ff;
    end
  end

  // per tap transition histogram: edge k lies between tap k and tap k+1
  for (genvar k = 0; k < PA_TAPS; k++)
  begin : g_edge
    logic edge_hit;
    if (k == PA_TAPS - 1)
    begin : g_wrap
      assign edge_hit = tap_last_ff ^ tap_s2_ff[0];
    end
    else
    begin : g_mid
      assign edge_hit = tap_s2_ff[k] ^ tap_s2_ff[k+1];
    end
    always_ff @(posedge lnk_clk)
    begin
      if (!lrst_b || (lce && (win_end || !l_pa_ff)))
      begin
        edge_cnt_ff[k] <= 8'h00;
      end
      else if (lce && edge_hit && (edge_cnt_ff[k] != 8'hFF))
      begin
        edge_cnt_ff[k] <= edge_cnt_ff[k] + 8'h01;
      end
    end
  end

  always_comb
  begin
    best     = 3'h0;
    best_cnt = edge_cnt_ff[0];
    for (int i = 1; i < PA_TAPS; i++)
    begin
      if (edge_cnt_ff[i] > best_cnt)
      begin
        best     = 3'(i);
        best_cnt = edge_cnt_ff[i];
      end
    end
  end

  // the eye centre sits half a bit, four taps, away from the busiest edge;
  // tracking continues after lock so slow skew drift is followed
  always_ff @(posedge lnk_clk)
  begin
    if (!lrst_b)
    begin
      pa_state_ff <= PA_BYPASS;
      win_cnt_ff  <= 8'h00;
      sel_ff      <= 3'h0;
    end
    else if (lce)
    begin
      win_cnt_ff <= (win_end || !l_pa_ff) ? 8'h00 : win_cnt_ff + 8'h01;
      case (pa_state_ff)
        PA_BYPASS:
        begin
          if (l_pa_ff)
          begin
            pa_state_ff <= PA_TRAIN;
          end
        end
        PA_TRAIN, PA_LOCKED:
        begin
          if (!l_pa_ff)
          begin
            pa_state_ff <= PA_BYPASS;
          end
          else if (win_end && (best_cnt != 8'h00))
          begin
            sel_ff      <= best + 3'h4;
            pa_state_ff <= PA_LOCKED;
          end
        end
        default:
        begin
          pa_state_ff <= PA_BYPASS;
        end
      endcase
    end
  end

  // phase select, then synchronizer, then realign and deserialize
  always_ff @(posedge lnk_clk)
  begin
    if (!lrst_b)
    begin
      sync_bit_ff <= 1'b0;
    end
    else if (lce)
    begin
      // bypass path also serves a clock-input pair used as data
      sync_bit_ff <= (pa_state_ff != PA_BYPASS) ? tap_s2_ff[sel_ff]
                                                : rx_pin_sync_ff[1];
    end
  end

  // a slip holds the bit counter for one bit, moving the boundary by one bit
  always_ff @(posedge lnk_clk)
  begin
    if (!lrst_b)
    begin
      sr_ff         <= '0;
      bit_cnt_ff    <= 4'h0;
      rx_x_word_ff  <= '0;
      rx_x_phase_ff <= 3'h0;
      rx_x_lock_ff  <= 1'b0;
      rx_tgl_ff     <= 1'b0;
      drop_tgl_ff   <= 1'b0;
    end
    else if (lce)
    begin
      sr_ff <= sr_nxt;
      if (slip_evt && (l_j_ff > 4'h2))
      begin
        bit_cnt_ff <= bit_cnt_ff;
      end
      else if (bit_cnt_ff >= l_j_m1)
      begin
        bit_cnt_ff <= 4'h0;
        if (!rx_busy)
        begin
          rx_x_word_ff  <= sr_nxt & word_mask;
          rx_x_phase_ff <= sel_ff;
          rx_x_lock_ff  <= pa_state_ff == PA_LOCKED;
          rx_tgl_ff     <= ~rx_tgl_ff;
        end
        else
        begin
          drop_tgl_ff <= ~drop_tgl_ff;
        end
      end
      else
      begin
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
    end
  end

  // transmit lane paired with the receive lane of the same logic_row
  always_ff @(posedge lnk_clk)
  begin
    if (!lrst_b)
    begin
      pend_ff       <= '0;
      pend_vld_ff   <= 1'b0;
      tx_ack_tgl_ff <= 1'b0;
      tx_sh_ff      <= '0;
      tx_cnt_ff     <= 4'h0;
      tx_serial_ff  <= 1'b0;
    end
    else if (lce)
    begin
      if (tx_evt)
      begin
        pend_ff     <= tx_hold_ff;
        pend_vld_ff <= 1'b1;
      end
      else if ((tx_cnt_ff == 4'h0) && pend_vld_ff)
      begin
        pend_vld_ff   <= 1'b0;
        tx_ack_tgl_ff <= ~tx_ack_tgl_ff;
      end
      tx_serial_ff <= tx_cur[l_j_m1];
      tx_sh_ff     <= tx_cur << 1;
      tx_cnt_ff    <= (tx_cnt_ff >= l_j_m1) ? 4'h0 : tx_cnt_ff + 4'h1;
    end
  end

  // forwarded clock: one period per w serial bits, high for the first (w+1)/2 of them
  always_ff @(posedge lnk_clk)
  begin
    if (!lrst_b)
    begin
      fwd_cnt_ff    <= 6'h00;
      tx_fwd_clk_ff <= 1'b0;
    end
    else if (lce)
    begin
      fwd_cnt_ff    <= (fwd_cnt_ff >= l_w_ff - 6'h01) ? 6'h00 : fwd_cnt_ff + 6'h01;
      tx_fwd_clk_ff <= fwd_cnt_ff < w_half;
    end
  end

  assign tx_serial  = tx_serial_ff;
  assign tx_fwd_clk = tx_fwd_clk_ff;

endmodule

// ---- tb/lvds_serdes_checker.sv ----
// concurrent checks on the apb and parallel word ports of the lvds channel
module lvds_serdes_checker
  import lvds_serdes_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic                clk,
  input wire logic                rst_b,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic [ADDR_W-1:0]   paddr,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic [WORD_MAX-1:0] rx_word,
  input wire logic                rx_word_vld,
  input wire logic                tx_word_vld,
  input wire logic                tx_word_rdy
);
  timeunit 1ns;
  timeprecision 100ps;
  //----------------------------------------------------------------------------
  // properties
  //----------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  property p_zero_wait;
    s_setup |=> s_access;
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("no ready after setup");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("lone error");
  property p_idle_data;
    !pready |-> prdata == 32'h00000000;
  endproperty
  a_idle_data: assert property (p_idle_data) else $error("read data outside access");
  property p_unmapped;
    s_setup ##0 (paddr > 8'h0B) |=> pslverr && prdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  property p_vld_pulse;
    rx_word_vld |=> !rx_word_vld;
  endproperty
  a_vld_pulse: assert property (p_vld_pulse) else $error("word valid held");
  property p_word_hold;
    $changed(rx_word) |-> rx_word_vld;
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("word changed silently");
  // the word must drain to the link and free the port again in bounded time
  property p_tx_take;
    tx_word_vld && tx_word_rdy |=> !tx_word_rdy ##[1:60] tx_word_rdy;
  endproperty
  a_tx_take: assert property (p_tx_take) else $error("transmit handshake");
endmodule

bind lvds_serdes_dpa_channel lvds_serdes_checker #(.ADDR_W(ADDR_W)) chk (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_word(rx_word),
  .rx_word_vld(rx_word_vld), .tx_word_vld(tx_word_vld), .tx_word_rdy(tx_word_rdy)
);

// ---- tb/lvds_far_end_model.sv ----
// far end of the link: repeating serial pattern on skewed taps, transmit bit capture
module lvds_far_end_model
  import lvds_serdes_pkg::*;
#(
  parameter int SKEW = 2
)
(
  input  wire logic                lnk_clk,
  input  wire logic [3:0]          j,
  input  wire logic [WORD_MAX-1:0] pat,
  input  wire logic                tx_serial,
  output logic                     rx_serial,
  output logic      [PA_TAPS-1:0]  rx_phase_taps,
  output logic      [WORD_MAX-1:0] tx_hist
);
  timeunit 1ns;
  timeprecision 100ps;
  int   idx      = 0;
  logic prev_bit = 1'b0;
  initial
  begin
    rx_serial = 1'b0;
    tx_hist   = 10'h000;
  end
  always @(posedge lnk_clk)
  begin
    prev_bit  <= rx_serial;
    rx_serial <= (idx < j) ? pat[j - 1 - idx] : 1'b0;
    idx       <= (idx + 1 >= j) ? 0 : idx + 1;
    tx_hist   <= {tx_hist[WORD_MAX-2:0], tx_serial};
  end
  // taps below SKEW lag one bit, so every data edge falls between taps SKEW-1 and SKEW
  always_comb
    for (int k = 0; k < PA_TAPS; k++)
      rx_phase_taps[k] = (k < SKEW) ? prev_bit : rx_serial;
endmodule

// ---- tb/testbench.sv ----
// self-checking bench: apb config, phase lock, realign, narrow modes and transmit
module testbench
  import lvds_serdes_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SKEW = 2;
  logic                clk         = 1'b0;
  logic                lnk_clk     = 1'b0;
  logic                rst_b       = 1'b0;
  logic                psel        = 1'b0;
  logic                penable     = 1'b0;
  logic                pwrite      = 1'b0;
  logic                realign_req = 1'b0;
  logic                tx_word_vld = 1'b0;
  logic [7:0]          paddr       = 8'h00;
  logic [31:0]         pwdata      = 32'h00000000;
  logic [WORD_MAX-1:0] tx_word     = 10'h000;
  logic [WORD_MAX-1:0] pat         = 10'h0E1;
  logic [31:0]         prdata, rd;
  logic                pready, pslverr, err, tx_serial, tx_fwd_clk, rx_serial;
  logic                rx_word_vld, tx_word_rdy, ok;
  logic [PA_TAPS-1:0]  taps;
  logic [WORD_MAX-1:0] rx_word, hist, w;
  int                  num_errors = 0;
  int                  n_compared = 0;
  int                  seed       = 32'h6e15413c;
  int                  ctrl_m, slips, i, n, wv, v;

  always #20 clk = ~clk;
  initial
  begin
    #1.7;
    forever #3 lnk_clk = ~lnk_clk;
  end

  lvds_serdes_dpa_channel #(.WIN_LEN(8)) dut (
    .clk, .rst_b, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .lnk_clk, .rx_serial, .rx_phase_taps(taps), .tx_serial, .tx_fwd_clk,
    .rx_word, .rx_word_vld, .realign_req, .tx_word, .tx_word_vld, .tx_word_rdy);
  lvds_far_end_model #(.SKEW(SKEW)) far (
    .lnk_clk, .j(ctrl_m[3:0]), .pat, .tx_serial, .rx_serial, .rx_phase_taps(taps),
    .tx_hist(hist));

  //----------------------------------------------------------------------------
  // shared tasks
  //----------------------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: %s saw %h want %h", $time, what, seen, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task set_ctrl(input int val);
    apb(1'b1, CTRL_OFS, val);
    check(32'(err), 32'h0, "ctrl write");
    ctrl_m = val;
  endtask
  task wait_vld(input int k);
    int c;
    repeat (k)
    begin
      c = 0;
      do
      begin
        @(posedge clk);
        c++;
      end
      while (rx_word_vld !== 1'b1 && c < 400);
      check(32'(rx_word_vld), 32'h1, "word valid");
    end
  endtask
  // one-cycle request, then enough words for it to cross and take effect
  task slip;
    @(posedge clk);
    realign_req <= 1'b1;
    @(posedge clk);
    realign_req <= 1'b0;
    wait_vld(3);
  endtask
  task final_report;
    if (num_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  //----------------------------------------------------------------------------
  // main sequence
  //----------------------------------------------------------------------------
  initial
  begin
    ctrl_m = (32'(TXEN_RST) << TXEN_BIT) | (32'(PAEN_RST) << PAEN_BIT)
           | (32'(W_RST) << W_LSB) | 32'(J_RST);
    slips = 0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, CTRL_OFS, 32'h0);
    check(rd, ctrl_m, "ctrl reset");
    apb(1'b0, 8'h40, 32'h0);
    check(32'(err), 32'h1, "unmapped error");
    check(rd, 32'h0, "unmapped data");
    for (i = 0; i < 12; i++)
    begin
      wv = (i == 5) ? 0 : ($random(seed) & 31) + 1;
      ok = (i inside {1, 2, [4:10]}) && wv != 0;
      v  = (ctrl_m & ~32'h3FF) | (wv << W_LSB) | i;
      apb(1'b1, CTRL_OFS, v);
      check(32'(err), 32'(!ok), "ctrl refusal");
      if (ok)
        ctrl_m = v;
      apb(1'b0, CTRL_OFS, 32'h0);
      check(rd, ctrl_m, "ctrl readback");
    end
    set_ctrl((ctrl_m & ~(1 << PAEN_BIT) & ~32'hF) | 8);
    wait_vld(3);
    apb(1'b0, STATUS_OFS, 32'h0);
    check(32'(rd[LOCK_BIT]), 32'h0, "bypass lock");
    for (i = 4; i <= 10; i++)
    begin
      set_ctrl((ctrl_m & ~32'hF) | (1 << PAEN_BIT) | i);
      wait_vld(4);
      apb(1'b0, STATUS_OFS, 32'h0);
      check(32'(rd[LOCK_BIT]), 32'h1, "lock");
      check(32'(rd[PHASE_LSB +: 3]), (SKEW - 1 + PA_TAPS / 2) % PA_TAPS, "phase");
    end
    set_ctrl((ctrl_m & ~32'hF) | 8);
    wait_vld(3);
    // the fabric side hunts for the pattern one slip at a time
    for (i = 0; i < 8 && rx_word !== pat; i++)
    begin
      slip();
      slips++;
    end
    check(32'(rx_word), 32'(pat), "aligned word");
    slip();
    slips++;
    check(32'(rx_word), 32'({pat[6:0], pat[7]}), "one bit slip");
    apb(1'b0, RXDATA_OFS, 32'h0);
    check(rd, 32'({pat[6:0], pat[7]}), "rxdata");
    apb(1'b0, STATUS_OFS, 32'h0);
    check(32'(rd[SLIP_LSB +: 8]), slips, "slip count");
    check(32'(rd[DROP_BIT]), 32'h1, "drop sticky");
    for (i = 1; i <= 2; i++)
    begin
      set_ctrl((ctrl_m & ~32'hF) | i);
      wait_vld(3);
      check(32'(rx_word >> i), 32'h0, "narrow word");
      check(32'(^rx_word), 32'h1, "narrow pairing");
      slip();
    end
    apb(1'b0, STATUS_OFS, 32'h0);
    check(32'(rd[SLIP_LSB +: 8]), slips, "narrow slips ignored");
    set_ctrl(ctrl_m & ~(1 << TXEN_BIT));
    repeat (2) @(posedge clk);
    check(32'(tx_word_rdy), 32'h0, "transmit disabled");
    set_ctrl((ctrl_m & ~32'hF) | (1 << TXEN_BIT) | 8);
    repeat (3)
    begin
      w = (10'($random(seed)) & 10'h0FF) | 10'h080;
      n = 0;
      @(posedge clk);
      while (tx_word_rdy !== 1'b1 && n < 100)
      begin
        @(posedge clk);
        n++;
      end
      tx_word     <= w;
      tx_word_vld <= 1'b1;
      @(posedge clk);
      tx_word_vld <= 1'b0;
      n = 0;
      while (hist[7:0] !== w[7:0] && n < 600)
      begin
        @(posedge lnk_clk);
        n++;
      end
      check(32'(hist[7:0]), 32'(w[7:0]), "serial word");
    end
    // any 20 bits hold four forwarded periods of 5, each high for 3 bits
    set_ctrl((ctrl_m & ~32'h3F0) | (5 << W_LSB));
    repeat (2) @(posedge clk);
    n = 0;
    repeat (20)
    begin
      @(posedge lnk_clk);
      if (tx_fwd_clk === 1'b1)
        n++;
    end
    check(n, 12, "forwarded clock");
    final_report();
  end

  initial
  begin
    #400000;
    num_errors++;
    final_report();
  end
endmodule
